// *** etcp_delay_path.sv ***
// Analog steering: comparator routing, pulse output and source ground
`timescale 1ns/1ps
module etcp_delay_path
  import etcp_pkg::*;
(
  // Mode and state
  input wire logic unit_on,
  input wire logic delay_gen_select,
  input wire logic charge_active,
  input wire logic source_discharge,
  // Comparator level, not tied to the clock
  input wire logic comparator_two_out,
  // Steering outputs
  output logic comparator_two_b_input,
  output logic delay_pulse_out,
  output logic source_ground
);
  import etcp_pkg::*;

  // ==========================================================
  // Routing and pulse
  // ==========================================================
  // Delay mode connects the current source to comparator two B
  assign comparator_two_b_input = unit_on & delay_gen_select; // R2
  // Pure gating: no flip-flop, so edges follow the comparator directly
  assign delay_pulse_out = comparator_two_b_input & charge_active &
    comparator_two_out; // R3 R4
  // Discharge grounds the source output, otherwise it floats
  assign source_ground = source_discharge; // R16

endmodule : etcp_delay_path

// *** etcp_edge_detect.sv ***
// Edge channel: source selector, polarity and edge detector
`timescale 1ns/1ps
module etcp_edge_detect
  import etcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Candidate sources
  input wire logic timer_event,
  input wire logic output_compare_one,
  input wire logic external_edge_pin_one,
  input wire logic external_edge_pin_two,
  // Channel settings
  input wire logic [1:0] edge_source,
  input wire logic edge_polarity,
  // One-cycle detection
  output logic edge_hit
);
  import etcp_pkg::*;

  logic chosen; // Selected source level
  logic prev; // Level one cycle ago

  // ==========================================================
  // Source selection
  // ==========================================================
  assign chosen = (edge_source == ETCP_SRC_PIN_ONE) ? external_edge_pin_one :
    (edge_source == ETCP_SRC_PIN_TWO) ? external_edge_pin_two :
    (edge_source == ETCP_SRC_COMPARE) ? output_compare_one :
    timer_event; // R7

  // History register; a source change can fake one edge, as in hardware
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prev <= 1'b0;
    else
      prev <= chosen;
  end

  // One selects rising, zero selects falling
  assign edge_hit = edge_polarity ? (chosen & ~prev) :
    (~chosen & prev); // R6

  a_polarity_edge: assert property ( // R6
    @(posedge clk_sys) disable iff (!rstn)
    edge_hit |-> (chosen == edge_polarity) && (prev != edge_polarity))
    else $error("edge hit against programmed polarity");

endmodule : etcp_edge_detect

// *** etcp_partner.sv ***
// Far-side model: edge source lines and the delay comparator with its capacitor
`timescale 1ns/1ps
module etcp_partner #(
  parameter int TRIP_CYCLES = 6 // Charge time of the capacitor to the trip level
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Requested levels: 0 timer, 1 compare, 2 pin two, 3 pin one
  input wire logic [3:0] src_cmd,
  // Analog steering seen from the unit
  input wire logic comparator_two_b_input,
  input wire logic source_ground,
  input wire logic current_source_on,
  // Source lines toward the unit
  output logic timer_event,
  output logic output_compare_one,
  output logic external_edge_pin_one,
  output logic external_edge_pin_two,
  // Comparator level, moves between clock edges on purpose
  output logic comparator_two_out
);
  int charge; // Capacitor charge, counted in clock cycles

  // ==========================================================
  // Source lines
  // ==========================================================
  // Peripherals change their levels one clock after the command
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      {external_edge_pin_one, external_edge_pin_two} <= 2'h0;
      {output_compare_one, timer_event} <= 2'h0;
    end
    else
    begin
      {external_edge_pin_one, external_edge_pin_two} <= src_cmd[3:2];
      {output_compare_one, timer_event} <= src_cmd[1:0];
    end
  end

  // ==========================================================
  // Capacitor and comparator
  // ==========================================================
  // The trip lands 2 ns after the edge, so an output that is
  // resampled by the clock would show up at the wrong moment
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      charge <= 0;
      comparator_two_out <= 1'b0;
    end
    else
    begin
      if (source_ground)
        charge <= 0; // Grounded source drains the capacitor
      else if (comparator_two_b_input && current_source_on)
        charge <= charge + 1; // Source routed and powered: charging
      comparator_two_out <= #2 (charge >= TRIP_CYCLES);
    end
  end
endmodule : etcp_partner

// *** etcp_pkg.sv ***
// Package: register map, field positions and codes of the edge timed unit
package etcp_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the 32-bit bus)
  // ==========================================================
  localparam logic [3:0] ETCP_CTRL_OFS = 4'h0; // measure_unit_control
  localparam logic [3:0] ETCP_ICON_OFS = 4'h4; // current_source_control
  localparam logic [3:0] ETCP_STAT_OFS = 4'h8; // Interrupt status
  localparam logic [3:0] ETCP_MASK_OFS = 4'hc; // Interrupt mask

  // ==========================================================
  // Field positions of measure_unit_control
  // ==========================================================
  localparam int ETCP_UNIT_ENABLE = 15;
  localparam int ETCP_UNUSED_BIT = 14;
  localparam int ETCP_IDLE_STOP = 13;
  localparam int ETCP_DELAY_GEN = 12;
  localparam int ETCP_EDGE_GATE = 11;
  localparam int ETCP_EDGE_ORDER = 10;
  localparam int ETCP_DISCHARGE = 9;
  localparam int ETCP_TRIG_EN = 8;
  localparam int ETCP_POL2 = 7;
  localparam int ETCP_SRC2_LSB = 5;
  localparam int ETCP_POL1 = 4;
  localparam int ETCP_SRC1_LSB = 2;
  localparam int ETCP_SEEN2 = 1;
  localparam int ETCP_SEEN1 = 0;

  // ==========================================================
  // Field positions of current_source_control
  // ==========================================================
  localparam int ETCP_TRIM_LSB = 10;
  localparam int ETCP_RANGE_LSB = 8;

  // Writable bits: bit 14 and the low byte of the current register stay 0
  localparam logic [15:0] ETCP_CTRL_WMASK = 16'hbfff;
  localparam logic [15:0] ETCP_ICON_WMASK = 16'hff00;

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [15:0] ETCP_CTRL_RST = 16'h0000;
  localparam logic [15:0] ETCP_ICON_RST = 16'h0000;
  localparam logic [1:0] ETCP_IRQ_RST = 2'h0;

  // ==========================================================
  // Codes
  // ==========================================================
  localparam logic [1:0] ETCP_SRC_TIMER = 2'h0;
  localparam logic [1:0] ETCP_SRC_COMPARE = 2'h1;
  localparam logic [1:0] ETCP_SRC_PIN_TWO = 2'h2;
  localparam logic [1:0] ETCP_SRC_PIN_ONE = 2'h3;
  localparam logic [1:0] ETCP_RANGE_OFF = 2'h0;

  // Bus answer state, one-hot
  typedef enum logic [1:0] {
    ETCP_BUS_IDLE = 2'b01,
    ETCP_BUS_DONE = 2'b10
  } etcp_bus_t;

endpackage : etcp_pkg

// *** etcp_unit.sv ***
// Top of the edge timed current pulse controller with Avalon-MM slave
//
// Operation
// R1: Unit runs only while unit_enable set
// R2: Delay select routes source to comparator B
// R3: Edge starts charge; trip asserts delay pulse
// R4: Output pulse edges are never clock resampled
// R5: Internal pulse spans first to second edge
// R6: Polarity bit: one rising, zero falling
// R7: Two-bit source selector per edge channel
// R8: Second edge flag set on qualifying event
// R9: First edge flag set on qualifying event
// R10: Trim field is signed offset
// R11: Zero trim nominal; all ones smallest negative
// R12: Range field scales or disables source
// R13: Unimplemented bits ignore writes, read zero
// R14: Edge gate enable blocks all edge events
// R15: Order enable: second edge needs first
// R16: Discharge grounds current source output
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module etcp_unit
  import etcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Edge sources
  input wire logic timer_event,
  input wire logic output_compare_one,
  input wire logic external_edge_pin_one,
  input wire logic external_edge_pin_two,
  // Comparator two output level
  input wire logic comparator_two_out,
  // Analog steering
  output logic comparator_two_b_input,
  output logic delay_pulse_out,
  output logic source_ground,
  output logic current_source_on,
  output logic [1:0] current_range,
  output logic [5:0] current_trim,
  // Measurement pulse and conversion trigger
  output logic measure_pulse,
  output logic adc_trigger,
  // Interrupt
  output logic irq
);
  import etcp_pkg::*;

  // ==========================================================
  // Helper: byte-lane merge of a 16-bit register
  // ==========================================================
  function automatic logic [15:0] etcp_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [15:0] wmask
  );
    logic [15:0] merged;
    merged = old_val;
    if (be[0])
      merged[7:0] = wdata[7:0];
    if (be[1])
      merged[15:8] = wdata[15:8];
    return merged & wmask;
  endfunction : etcp_merge

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [15:0] ctrl; // measure_unit_control, flags held apart
  logic [15:0] icon; // current_source_control
  logic first_edge_seen; // Sticky edge-1 flag
  logic second_edge_seen; // Sticky edge-2 flag
  logic [1:0] irq_status; // Sticky event bits
  logic [1:0] irq_mask; // Event enables
  etcp_bus_t bus_state; // Bus answer phase
  etcp_bus_t next_bus_state;
  logic [31:0] next_readdata;
  logic [15:0] next_ctrl;
  logic [15:0] next_icon;
  logic [15:0] ctrl_view; // Register as software sees it
  logic [15:0] ctrl_wr_val; // Value a write would leave
  logic req; // Any request present
  logic commit; // Edge at which the access completes
  logic wr_ctrl;
  logic wr_icon;
  logic wr_stat;
  logic wr_mask;
  logic hit1; // Raw edge detections
  logic hit2;
  logic unit_on;
  logic edge_gate_enable;
  logic edge_order_enable;
  logic ev1; // Qualified edge events
  logic ev2;
  logic charge_active;

  // ==========================================================
  // Bus decode
  // ==========================================================
  assign req = avs_read | avs_write;
  assign commit = req & (bus_state == ETCP_BUS_DONE);
  // One wait cycle: the read word is registered first
  assign avs_waitrequest = req & (bus_state != ETCP_BUS_DONE);
  assign wr_ctrl = commit & avs_write & (avs_address == ETCP_CTRL_OFS);
  assign wr_icon = commit & avs_write & (avs_address == ETCP_ICON_OFS);
  assign wr_stat = commit & avs_write & (avs_address == ETCP_STAT_OFS) &
    avs_byteenable[0];
  assign wr_mask = commit & avs_write & (avs_address == ETCP_MASK_OFS) &
    avs_byteenable[0];

  // Flags live outside ctrl so hardware can set them
  assign ctrl_view = {ctrl[15:2], second_edge_seen, first_edge_seen};
  assign ctrl_wr_val = etcp_merge(ctrl_view, avs_writedata, avs_byteenable,
    ETCP_CTRL_WMASK); // R13
  assign next_ctrl = wr_ctrl ? ctrl_wr_val : ctrl;
  assign next_icon = wr_icon ?
    etcp_merge(icon, avs_writedata, avs_byteenable, ETCP_ICON_WMASK) :
    icon; // R13

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    if (avs_address == ETCP_CTRL_OFS)
      next_readdata = {16'h0000, ctrl_view & ETCP_CTRL_WMASK}; // R13
    else if (avs_address == ETCP_ICON_OFS)
      next_readdata = {16'h0000, icon & ETCP_ICON_WMASK}; // R13
    else if (avs_address == ETCP_STAT_OFS)
      next_readdata = {30'h00000000, irq_status};
    else if (avs_address == ETCP_MASK_OFS)
      next_readdata = {30'h00000000, irq_mask};
    else
      next_readdata = 32'h00000000;
  end

  // Answer state: idle to done for one cycle, then back
  always_comb
  begin
    case (bus_state)
      ETCP_BUS_IDLE:
        next_bus_state = req ? ETCP_BUS_DONE : ETCP_BUS_IDLE;
      ETCP_BUS_DONE:
        next_bus_state = ETCP_BUS_IDLE;
      default:
        next_bus_state = ETCP_BUS_IDLE;
    endcase
  end

  // ==========================================================
  // Bus registers
  // ==========================================================
  // Read data is caught in the wait cycle and stands on the answer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_state <= ETCP_BUS_IDLE;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      bus_state <= next_bus_state;
      if (req && bus_state == ETCP_BUS_IDLE)
        avs_readdata <= next_readdata;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= ETCP_CTRL_RST;
      icon <= ETCP_ICON_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      icon <= next_icon;
    end
  end

  // ==========================================================
  // Edge channels
  // ==========================================================
  etcp_edge_detect u_edge1 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .timer_event(timer_event),
    .output_compare_one(output_compare_one),
    .external_edge_pin_one(external_edge_pin_one),
    .external_edge_pin_two(external_edge_pin_two),
    .edge_source(ctrl[ETCP_SRC1_LSB +: 2]),
    .edge_polarity(ctrl[ETCP_POL1]),
    .edge_hit(hit1)
  );

  etcp_edge_detect u_edge2 (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .timer_event(timer_event),
    .output_compare_one(output_compare_one),
    .external_edge_pin_one(external_edge_pin_one),
    .external_edge_pin_two(external_edge_pin_two),
    .edge_source(ctrl[ETCP_SRC2_LSB +: 2]),
    .edge_polarity(ctrl[ETCP_POL2]),
    .edge_hit(hit2)
  );

  // ==========================================================
  // Event qualification
  // ==========================================================
  assign unit_on = ctrl[ETCP_UNIT_ENABLE]; // R1
  assign edge_gate_enable = ctrl[ETCP_EDGE_GATE];
  assign edge_order_enable = ctrl[ETCP_EDGE_ORDER];
  assign ev1 = unit_on & edge_gate_enable & hit1; // R1 R14
  // With ordering on, edge 2 counts only after edge 1 was recorded
  assign ev2 = unit_on & edge_gate_enable & hit2 &
    (~edge_order_enable | first_edge_seen); // R14 R15

  // Sticky flags: an event in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      first_edge_seen <= 1'b0;
      second_edge_seen <= 1'b0;
    end
    else
    begin
      first_edge_seen <= ev1 |
        (wr_ctrl ? ctrl_wr_val[ETCP_SEEN1] : first_edge_seen); // R9
      second_edge_seen <= ev2 |
        (wr_ctrl ? ctrl_wr_val[ETCP_SEEN2] : second_edge_seen); // R8
    end
  end

  // Interrupt status: set by events, cleared by writing one
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_status <= ETCP_IRQ_RST;
      irq_mask <= ETCP_IRQ_RST;
    end
    else
    begin
      irq_status <= {ev2, ev1} |
        (irq_status & ~({2{wr_stat}} & avs_writedata[1:0]));
      if (wr_mask)
        irq_mask <= avs_writedata[1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Current source and pulses
  // ==========================================================
  // Charging spans first event to second; software clears to rearm
  assign charge_active = unit_on & first_edge_seen & ~second_edge_seen; // R3
  // Measurement pulse width equals edge-to-edge time
  assign measure_pulse = charge_active & ~ctrl[ETCP_DELAY_GEN]; // R5
  // Range 00 turns the source off; trim is passed on as signed offset
  assign current_range = icon[ETCP_RANGE_LSB +: 2]; // R12
  assign current_trim = icon[ETCP_TRIM_LSB +: 6]; // R10 R11
  assign current_source_on = charge_active &
    (current_range != ETCP_RANGE_OFF); // R3 R12
  // Trigger for a conversion once the second edge lands
  assign adc_trigger = unit_on & ctrl[ETCP_TRIG_EN] & second_edge_seen;

  etcp_delay_path u_delay (
    .unit_on(unit_on),
    .delay_gen_select(ctrl[ETCP_DELAY_GEN]),
    .charge_active(charge_active),
    .source_discharge(ctrl[ETCP_DISCHARGE]),
    .comparator_two_out(comparator_two_out),
    .comparator_two_b_input(comparator_two_b_input),
    .delay_pulse_out(delay_pulse_out),
    .source_ground(source_ground)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_new_req;
    req && bus_state == ETCP_BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest && req;
  endsequence

  a_bus_answer_time: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_new_req |-> avs_waitrequest ##1 s_answer)
    else $error("bus answer not after one wait cycle");

  a_unit_off_quiet: assert property ( // R1
    @(posedge clk_sys) disable iff (!rstn)
    !unit_on |-> !ev1 && !ev2 && !current_source_on && !charge_active)
    else $error("unit active while disabled");

  a_second_flag_set: assert property ( // R8
    @(posedge clk_sys) disable iff (!rstn)
    ev2 |=> second_edge_seen)
    else $error("second edge flag not set");

  a_first_flag_set: assert property ( // R9
    @(posedge clk_sys) disable iff (!rstn)
    ev1 |=> first_edge_seen)
    else $error("first edge flag not set");

  a_flag_no_event: assert property ( // R9
    @(posedge clk_sys) disable iff (!rstn)
    !first_edge_seen && !ev1 && !wr_ctrl |=> !first_edge_seen)
    else $error("first edge flag rose without cause");

  a_gate_blocks: assert property ( // R14
    @(posedge clk_sys) disable iff (!rstn)
    !edge_gate_enable && !wr_ctrl |=> $stable(second_edge_seen))
    else $error("flag changed while edges gated");

  a_order_holds: assert property ( // R15
    @(posedge clk_sys) disable iff (!rstn)
    edge_order_enable && !first_edge_seen |-> !ev2)
    else $error("edge 2 accepted before edge 1");

  a_delay_route: assert property ( // R2
    @(posedge clk_sys) disable iff (!rstn)
    unit_on && ctrl[ETCP_DELAY_GEN] |-> comparator_two_b_input)
    else $error("delay mode not routed");

  a_pulse_direct: assert property ( // R3
    @(posedge clk_sys) disable iff (!rstn)
    delay_pulse_out == (comparator_two_b_input && charge_active &&
      comparator_two_out))
    else $error("delay pulse not tied to trip level");

  a_measure_width: assert property ( // R5
    @(posedge clk_sys) disable iff (!rstn)
    ev2 && !ctrl[ETCP_DELAY_GEN] && !wr_ctrl |=> !measure_pulse)
    else $error("measure pulse outlived second edge");

  a_range_off: assert property ( // R12
    @(posedge clk_sys) disable iff (!rstn)
    current_range == ETCP_RANGE_OFF |-> !current_source_on)
    else $error("source on with range off");

  a_unused_zero: assert property ( // R13
    @(posedge clk_sys) disable iff (!rstn)
    commit && avs_read && avs_address == ETCP_ICON_OFS |->
      avs_readdata[7:0] == 8'h00 && avs_readdata[31:16] == 16'h0000)
    else $error("unimplemented bits read nonzero");

  a_discharge_ground: assert property ( // R16
    @(posedge clk_sys) disable iff (!rstn)
    ctrl[ETCP_DISCHARGE] |-> source_ground)
    else $error("discharge set but source floating");

endmodule : etcp_unit

// *** etcp_unit_bench.sv ***
// Self-checking bench of the edge timed current pulse controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module etcp_unit_bench;
  import etcp_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk_sys = 1'b0; // 125 MHz system clock
  logic rstn = 1'b0; // Active low reset
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3; // Both used lanes always on
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] src_cmd = 4'h0; // Levels asked of the far side
  logic timer_event, output_compare_one, pin_one, pin_two, cmp_out;
  logic b_input, delay_pulse_out, source_ground, current_source_on;
  logic [1:0] current_range;
  logic [5:0] current_trim;
  logic measure_pulse, adc_trigger, irq;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  etcp_unit i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_event(timer_event), .output_compare_one(output_compare_one),
    .external_edge_pin_one(pin_one), .external_edge_pin_two(pin_two),
    .comparator_two_out(cmp_out), .comparator_two_b_input(b_input),
    .delay_pulse_out(delay_pulse_out), .source_ground(source_ground),
    .current_source_on(current_source_on), .current_range(current_range),
    .current_trim(current_trim), .measure_pulse(measure_pulse),
    .adc_trigger(adc_trigger), .irq(irq));

  etcp_partner i_far (.clk_sys(clk_sys), .rstn(rstn), .src_cmd(src_cmd),
    .comparator_two_b_input(b_input), .source_ground(source_ground),
    .current_source_on(current_source_on), .timer_event(timer_event),
    .output_compare_one(output_compare_one),
    .external_edge_pin_one(pin_one), .external_edge_pin_two(pin_two),
    .comparator_two_out(cmp_out));

  // ==========================================================
  // Bus and stimulus helpers
  // ==========================================================
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [3:0] adr,
    input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_sys);
    avs_address <= adr;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys); // The cycle ceiling ends a hang
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_xfer

  task automatic wr16(input logic [3:0] adr, input logic [15:0] d);
    logic [15:0] unused;
    bus_xfer(1'b1, adr, d, unused);
  endtask : wr16

  task automatic rd_chk(input logic [3:0] adr, input logic [15:0] ex,
    input string nm);
    logic [15:0] got;
    bus_xfer(1'b0, adr, 16'h0000, got);
    `CHK(nm, ex, got)
  endtask : rd_chk

  // New source levels, then time for the unit to see them
  task automatic lines(input logic [3:0] v);
    @(posedge clk_sys);
    src_cmd <= v;
    repeat (4) @(posedge clk_sys);
  endtask : lines

  // Lets the updates of the last edge land before outputs are judged
  task automatic settle;
    @(negedge clk_sys);
  endtask : settle

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset_and_map;
    rd_chk(ETCP_CTRL_OFS, 16'h0000, "control after reset");
    rd_chk(ETCP_STAT_OFS, 16'h0000, "status after reset");
    rd_chk(ETCP_MASK_OFS, 16'h0000, "mask after reset");
    wr16(ETCP_CTRL_OFS, 16'hffff);
    rd_chk(ETCP_CTRL_OFS, 16'hbfff, "control bit 14");
    rd_chk(4'h1, 16'h0000, "unmapped read");
    wr16(ETCP_ICON_OFS, 16'hffff);
    rd_chk(ETCP_ICON_OFS, 16'hff00, "current low byte");
    wr16(ETCP_CTRL_OFS, 16'h0000);
  endtask : t_reset_and_map

  task automatic t_current;
    logic [5:0] trims [4] = '{6'h1f, 6'h21, 6'h00, 6'h3f};
    wr16(ETCP_CTRL_OFS, 16'h8001);
    for (int r = 0; r < 4; r++)
    begin
      wr16(ETCP_ICON_OFS, {6'h00, r[1:0], 8'h00});
      settle();
      `CHK("range", r[1:0], current_range)
      `CHK("source on", (r != 0), current_source_on)
    end
    foreach (trims[i])
    begin
      wr16(ETCP_ICON_OFS, {trims[i], 2'b01, 8'h00});
      settle();
      `CHK("trim", trims[i], current_trim)
    end
  endtask : t_current

  // One channel, one source code, one polarity; the other channel
  // watches a line that never moves in its own direction
  task automatic t_edge(input logic ch2, input logic [1:0] code,
    input logic pol);
    logic [15:0] c;
    logic [3:0] idle;
    logic [3:0] sel;
    logic [3:0] oth;
    idle = {4{pol}};
    sel = 4'b0001 << code;
    oth = 4'b0001 << 2'(code + 2'd1);
    c = 16'h8800;
    c[ETCP_SRC1_LSB +: 2] = ch2 ? 2'(code + 2'd2) : code;
    c[ETCP_SRC2_LSB +: 2] = ch2 ? code : 2'(code + 2'd2);
    c[ETCP_POL1] = pol;
    c[ETCP_POL2] = pol;
    lines(idle);
    wr16(ETCP_CTRL_OFS, c);
    lines(~idle);
    rd_chk(ETCP_CTRL_OFS, c, "wrong direction");
    lines(~idle ^ oth);
    rd_chk(ETCP_CTRL_OFS, c, "other source");
    lines(~idle ^ oth ^ sel);
    rd_chk(ETCP_CTRL_OFS, c | (ch2 ? 16'h2 : 16'h1), "edge flag");
  endtask : t_edge

  task automatic t_gates;
    lines(4'h0);
    wr16(ETCP_CTRL_OFS, 16'h801c);
    wr16(ETCP_STAT_OFS, 16'h0003);
    lines(4'hf);
    rd_chk(ETCP_CTRL_OFS, 16'h801c, "edge gate off");
    lines(4'h0);
    wr16(ETCP_CTRL_OFS, 16'h081c);
    lines(4'hf);
    rd_chk(ETCP_CTRL_OFS, 16'h081c, "unit off");
    rd_chk(ETCP_STAT_OFS, 16'h0000, "status while gated");
  endtask : t_gates

  task automatic t_order_irq;
    lines(4'h0);
    wr16(ETCP_CTRL_OFS, 16'h8ddc);
    wr16(ETCP_STAT_OFS, 16'h0003);
    wr16(ETCP_MASK_OFS, 16'h0000);
    lines(4'b0100);
    rd_chk(ETCP_CTRL_OFS, 16'h8ddc, "second before first");
    lines(4'b1100);
    rd_chk(ETCP_CTRL_OFS, 16'h8ddd, "first edge");
    settle();
    `CHK("pulse open", 1'b1, measure_pulse)
    `CHK("masked irq", 1'b0, irq)
    wr16(ETCP_MASK_OFS, 16'h0001);
    settle();
    `CHK("unmasked irq", 1'b1, irq)
    lines(4'b1000);
    lines(4'b1100);
    rd_chk(ETCP_CTRL_OFS, 16'h8ddf, "second after first");
    settle();
    `CHK("pulse closed", 1'b0, measure_pulse)
    `CHK("trigger", 1'b1, adc_trigger)
    wr16(ETCP_STAT_OFS, 16'h0001);
    rd_chk(ETCP_STAT_OFS, 16'h0002, "status clear one");
    settle();
    `CHK("irq after clear", 1'b0, irq)
    wr16(ETCP_MASK_OFS, 16'h0002);
    settle();
    `CHK("irq second", 1'b1, irq)
    wr16(ETCP_STAT_OFS, 16'h0002);
    settle();
    `CHK("irq cleared", 1'b0, irq)
  endtask : t_order_irq

  task automatic t_delay;
    time t_rise = 0;
    wr16(ETCP_ICON_OFS, 16'h0100);
    lines(4'h0);
    wr16(ETCP_CTRL_OFS, 16'h9adc);
    settle();
    `CHK("route to comparator", 1'b1, b_input)
    `CHK("grounded", 1'b1, source_ground)
    lines(4'b1000);
    `CHK("no trip while grounded", 1'b0, delay_pulse_out)
    wr16(ETCP_CTRL_OFS, 16'h98dd);
    fork
      begin
        @(posedge delay_pulse_out);
        t_rise = $time;
      end
      repeat (40) @(posedge clk_sys);
    join_any
    disable fork;
    `CHK("pulse rises", 1'b1, delay_pulse_out)
    `CHK("pulse off clock", 4'h6, 4'(t_rise % 8))
    lines(4'b1100);
    `CHK("pulse ends", 1'b0, delay_pulse_out)
    wr16(ETCP_CTRL_OFS, 16'h0000);
    settle();
    `CHK("route off", 1'b0, b_input)
  endtask : t_delay

  // ==========================================================
  // Run control
  // ==========================================================
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the fewer than one thousand cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset_and_map();
    t_current();
    for (int k = 0; k < 16; k++)
      t_edge(k[0], k[2:1], k[3]);
    t_gates();
    t_order_irq();
    t_delay();
    report_and_stop();
  end
endmodule : etcp_unit_bench
